// >>> logic/mprc_map.svh
// Register offsets, field positions, functionality codes and timing counts for the power sequencer
`ifndef MPRC_MAP_SVH
`define MPRC_MAP_SVH
// Timing figures, in milliseconds
`define MPRC_ON_MS 500
`define MPRC_OFF_MS 650
`define MPRC_RST_MS 300
`define MPRC_LOGOUT_MS 2000
// Clock rate in kilohertz, so cycles = ms * kHz
`define MPRC_CLK_KHZ 50000
// Register byte offsets
`define MPRC_OFS_CTRL 8'h00
`define MPRC_OFS_STATUS 8'h04
`define MPRC_OFS_FUNC 8'h08
`define MPRC_OFS_CMD 8'h0C
// Control fields
`define MPRC_CTRL_PINCFG 0
// Command fields (write one to fire)
`define MPRC_CMD_SHUTDOWN 0
`define MPRC_CMD_RFCMD 1
// Status fields
`define MPRC_ST_STATE_LSB 0
`define MPRC_ST_RF_ON 4
`define MPRC_ST_SIM_ON 5
`define MPRC_ST_AIRPLANE 6
`define MPRC_ST_BB_RST 7
`define MPRC_ST_RF_REJ 8
// Functionality codes
`define MPRC_FUN_MIN 3'h0
`define MPRC_FUN_FULL 3'h1
`define MPRC_FUN_RFOFF 3'h4
`endif

// >>> logic/mprc_pkg.sv
// Types shared by the power sequencer files
package mprc_pkg;
  // Power state machine
  typedef enum logic [2:0] {
    MPRC_OFF = 3'b000,
    MPRC_BOOT = 3'b001,
    MPRC_ON = 3'b010,
    MPRC_OFF_ARMED = 3'b011,
    MPRC_LOGOUT = 3'b100
  } mprc_state_t;
endpackage : mprc_pkg

// >>> logic/mprc_sync.sv
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module mprc_sync #(
  parameter logic RESET_VAL = 1'b1
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_d,
  output logic o_q
);
  // First stage is read only by the second
  logic meta_r;
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      meta_r <= RESET_VAL;
      o_q <= RESET_VAL;
    end else begin
      meta_r <= i_d;
      o_q <= meta_r;
    end
  end
endmodule : mprc_sync

// >>> logic/mprc_lowtimer.sv
// Counts how long a synchronised active-low input has been low
`timescale 1ns/1ps
module mprc_lowtimer #(
  parameter int unsigned WIDTH = 26,
  parameter int unsigned LIMIT = 100
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_low,
  output logic o_reached
);
  // Refuse limits the counter cannot reach
  initial begin
    if (LIMIT < 1 || LIMIT >= (64'd1 << WIDTH)) begin
      $error("mprc_lowtimer: LIMIT does not fit WIDTH");
    end
  end
  logic [WIDTH-1:0] cnt_r;
  logic [WIDTH-1:0] cnt_nxt;
  localparam logic [WIDTH-1:0] LIM = LIMIT[WIDTH-1:0];
  // Saturate at the limit so long holds never wrap
  assign cnt_nxt = !i_low ? '0 : (cnt_r == LIM) ? cnt_r : cnt_r + 1'b1;
  assign o_reached = (cnt_r == LIM);
  // Count low cycles
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end
endmodule : mprc_lowtimer

// >>> logic/mprc_power_ctrl.sv
// Power-on, power-off, baseband restart and RF-off control with AHB-Lite registers
//
// Design decisions made here: the AHB-Lite slave port and the register addresses.
`timescale 1ns/1ps
`include "mprc_map.svh"
module mprc_power_ctrl
  import mprc_pkg::*;
#(
  parameter int unsigned CLK_KHZ = `MPRC_CLK_KHZ,
  parameter int unsigned ON_CYCLES = `MPRC_ON_MS * `MPRC_CLK_KHZ,
  parameter int unsigned OFF_CYCLES = `MPRC_OFF_MS * `MPRC_CLK_KHZ,
  parameter int unsigned RST_CYCLES = `MPRC_RST_MS * `MPRC_CLK_KHZ,
  parameter int unsigned BOOT_CYCLES = 1000,
  parameter int unsigned LOGOUT_CYCLES = `MPRC_LOGOUT_MS * `MPRC_CLK_KHZ
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_power_key_n,
  input wire logic i_restart_n,
  input wire logic i_rf_off_n,
  input wire logic i_rf_cmd_req,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hsel,
  input wire logic i_hready,
  output logic [31:0] o_hrdata,
  output logic o_hreadyout,
  output logic o_hresp,
  output logic o_powered,
  output logic o_bb_rst,
  output logic o_rf_en,
  output logic o_sim_en,
  output logic o_rf_cmd_ack,
  output logic o_rf_cmd_rej
);
  // Counter width; 32 bits holds the longest count at the full clock rate
  localparam int unsigned CW = 32;

  // Refuse counts of less than one cycle
  initial begin
    if (ON_CYCLES < 1 || OFF_CYCLES < 1 || RST_CYCLES < 1 ||
        BOOT_CYCLES < 1 || LOGOUT_CYCLES < 1) begin
      $error("mprc_power_ctrl: timing counts must be at least one cycle");
    end
  end

  // Functionality code check shared by write decode
  // Only codes 0, 1 and 4 exist; anything else is dropped
  function automatic logic fun_code_ok(input logic [2:0] code);
    fun_code_ok = (code == `MPRC_FUN_MIN) || (code == `MPRC_FUN_FULL) ||
                  (code == `MPRC_FUN_RFOFF);
  endfunction : fun_code_ok

  // Synchronised pins, idle high after reset
  // The pins come from the host's domain, so each passes two flops
  // Reset value matches the idle level, so no false press after reset
  logic key_n_s;
  logic rst_n_s;
  logic rfoff_n_s;
  mprc_sync #(.RESET_VAL(1'b1)) u_sync_key (
    .i_clk(i_clk), .i_rst(i_rst), .i_d(i_power_key_n), .o_q(key_n_s)
  );
  mprc_sync #(.RESET_VAL(1'b1)) u_sync_rst (
    .i_clk(i_clk), .i_rst(i_rst), .i_d(i_restart_n), .o_q(rst_n_s)
  );
  mprc_sync #(.RESET_VAL(1'b1)) u_sync_rfoff (
    .i_clk(i_clk), .i_rst(i_rst), .i_d(i_rf_off_n), .o_q(rfoff_n_s)
  );

  // Key is active low: low level is a request
  wire key_low = ~key_n_s;
  // Restart pin only counts once turn-on is complete
  logic running;
  wire rst_low = ~rst_n_s & running;

  // Low-interval timers on our own clock
  // Each timer saturates, so a long hold never wraps into a short one
  // On and off timers watch the same key; the state picks the one used
  wire on_reached;
  wire off_reached;
  wire rst_reached;
  mprc_lowtimer #(.WIDTH(CW), .LIMIT(ON_CYCLES)) u_on_tmr (
    .i_clk(i_clk), .i_rst(i_rst), .i_low(key_low), .o_reached(on_reached)
  );
  mprc_lowtimer #(.WIDTH(CW), .LIMIT(OFF_CYCLES)) u_off_tmr (
    .i_clk(i_clk), .i_rst(i_rst), .i_low(key_low), .o_reached(off_reached)
  );
  mprc_lowtimer #(.WIDTH(CW), .LIMIT(RST_CYCLES)) u_rst_tmr (
    .i_clk(i_clk), .i_rst(i_rst), .i_low(rst_low), .o_reached(rst_reached)
  );

  // Power state and its phase counter
  // Phase counts boot and logout time in clock cycles
  mprc_state_t state_r;
  mprc_state_t state_nxt;
  logic [CW-1:0] phase_r;
  logic [CW-1:0] phase_nxt;
  // Software-visible control
  logic pincfg_r; // RF-off pin enable, off after power-up
  logic [2:0] fun_r; // Functionality level
  logic shutdown_pend_r; // Shutdown command waiting for ON
  logic rst_armed_r; // Restart held long enough
  logic bb_rst_r; // Baseband reset pulse active
  logic [CW-1:0] bbcnt_r;
  logic rf_rej_r; // Sticky: an RF command was rejected in airplane mode
  // One-cycle answers to an RF-dependent command
  logic ack_r;
  logic rej_r;

  // AHB-Lite address phase capture
  // Only the low address byte is decoded; upper bits alias
  logic wr_pend_r;
  logic rd_pend_r;
  logic [7:0] addr_r;
  // NONSEQ and SEQ have bit 1 set; IDLE and BUSY do not
  wire ahb_go = i_hsel & i_hready & i_htrans[1];
  wire wr_ctrl = wr_pend_r && (addr_r == `MPRC_OFS_CTRL);
  wire wr_func = wr_pend_r && (addr_r == `MPRC_OFS_FUNC);
  wire wr_cmd = wr_pend_r && (addr_r == `MPRC_OFS_CMD);
  wire shut_cmd = wr_cmd & i_hwdata[`MPRC_CMD_SHUTDOWN];
  wire rf_soft_cmd = wr_cmd & i_hwdata[`MPRC_CMD_RFCMD];

  // Airplane when code says RF off or enabled pin is low
  wire pin_airplane = pincfg_r & ~rfoff_n_s;
  wire rf_off_mode = (fun_r != `MPRC_FUN_FULL) | pin_airplane;
  // Still running while a turn-off press waits for its release
  assign running = (state_r == MPRC_ON) || (state_r == MPRC_OFF_ARMED);
  wire rf_req = i_rf_cmd_req | rf_soft_cmd;
  // RF commands are served only while the radio is really up
  wire rf_ok = running & ~rf_off_mode & ~bb_rst_r;

  // Power state transitions
  // Single next-state process over binary-coded states
  always_comb begin
    state_nxt = state_r;
    phase_nxt = '0;
    case (state_r)
      MPRC_OFF: begin
        // Start once the key has been low long enough
        if (on_reached) begin
          state_nxt = MPRC_BOOT;
        end
      end
      MPRC_BOOT: begin
        // Wait for the key release before counting it as a new press
        phase_nxt = phase_r + 1'b1;
        if (phase_r >= BOOT_CYCLES[CW-1:0] - 1'b1 && !key_low) begin
          state_nxt = MPRC_ON;
          phase_nxt = '0;
        end else if (phase_r >= BOOT_CYCLES[CW-1:0] - 1'b1) begin
          // Key still held: park the counter until release
          phase_nxt = phase_r;
        end
      end
      MPRC_ON: begin
        if (off_reached) begin
          state_nxt = MPRC_OFF_ARMED;
        end else if (shutdown_pend_r) begin
          // Shutdown command follows the same logout path as the key
          state_nxt = MPRC_LOGOUT;
        end
      end
      MPRC_OFF_ARMED: begin
        // Power-down starts only once the key is back high
        if (!key_low) begin
          state_nxt = MPRC_LOGOUT;
        end
      end
      MPRC_LOGOUT: begin
        // Network logout, then power off
        phase_nxt = phase_r + 1'b1;
        if (phase_r >= LOGOUT_CYCLES[CW-1:0] - 1'b1) begin
          state_nxt = MPRC_OFF;
          phase_nxt = '0;
        end
      end
      default: begin
        // Unused codes fall back to powered off
        state_nxt = MPRC_OFF;
      end
    endcase
  end

  // Power state registers; a key still low after logout restarts via OFF
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state_r <= MPRC_OFF;
      phase_r <= '0;
    end else begin
      // Next-state logic clears the phase counter on every move
      state_r <= state_nxt;
      phase_r <= phase_nxt;
    end
  end

  // Restart: armed after 300 ms low, reset fires on release
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      rst_armed_r <= 1'b0;
      bb_rst_r <= 1'b0;
      bbcnt_r <= '0;
    end else begin
      if (!running) begin
        // Ignored unless running, so also while off, booting or logging out
        rst_armed_r <= 1'b0;
        bb_rst_r <= 1'b0;
      end else if (rst_reached) begin
        // Pin still low: arm, but wait for the release
        rst_armed_r <= 1'b1;
      end else if (rst_armed_r && rst_n_s) begin
        rst_armed_r <= 1'b0;
        bb_rst_r <= 1'b1;
        bbcnt_r <= '0;
      end else if (bb_rst_r) begin
        // Pulse length reuses the boot time
        bbcnt_r <= bbcnt_r + 1'b1;
        if (bbcnt_r >= BOOT_CYCLES[CW-1:0] - 1'b1) begin
          bb_rst_r <= 1'b0;
        end
      end
    end
  end

  // Bus phase capture; single-cycle answers, always OKAY
  // Zero wait states, so every selected address phase is taken
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      wr_pend_r <= 1'b0;
      rd_pend_r <= 1'b0;
      addr_r <= 8'h00;
    end else begin
      wr_pend_r <= ahb_go & i_hwrite;
      rd_pend_r <= ahb_go & ~i_hwrite;
      if (ahb_go) begin
        addr_r <= i_haddr[7:0];
      end
    end
  end

  // Software control; functionality and pin config survive baseband reset
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      pincfg_r <= 1'b0;
      fun_r <= `MPRC_FUN_FULL;
      shutdown_pend_r <= 1'b0;
    end else begin
      if (state_r == MPRC_OFF) begin
        // Power-up defaults on every fresh start
        pincfg_r <= 1'b0;
        fun_r <= `MPRC_FUN_FULL;
        shutdown_pend_r <= 1'b0;
      end else begin
        // RF-off pin control follows bit 0
        if (wr_ctrl) begin
          pincfg_r <= i_hwdata[`MPRC_CTRL_PINCFG];
        end
        // Illegal function codes leave the level unchanged
        if (wr_func && fun_code_ok(i_hwdata[2:0])) begin
          fun_r <= i_hwdata[2:0];
        end
        // Shutdown is only taken while the module is running
        if (shut_cmd && running) begin
          shutdown_pend_r <= 1'b1;
        end else if (state_r == MPRC_LOGOUT) begin
          shutdown_pend_r <= 1'b0;
        end
      end
    end
  end

  // RF-dependent command gate; set wins over a status read clear
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      ack_r <= 1'b0;
      rej_r <= 1'b0;
      rf_rej_r <= 1'b0;
    end else begin
      ack_r <= rf_req & rf_ok;
      rej_r <= rf_req & ~rf_ok;
      // Only the airplane case is remembered for software
      if (rf_req & rf_off_mode) begin
        rf_rej_r <= 1'b1;
      end else if (rd_pend_r && addr_r == `MPRC_OFS_STATUS &&
                   o_hrdata[`MPRC_ST_RF_REJ]) begin
        // Clear only what the read has shown, so no reject is lost
        rf_rej_r <= 1'b0;
      end
    end
  end

  // Status word; bit 3 is spare and reads zero
  wire [31:0] status_w = {23'h000000, rf_rej_r, bb_rst_r, rf_off_mode,
                          o_sim_en, o_rf_en, 1'b0, state_r};
  // Read decode uses the address phase, so data is ready for the data phase
  wire [7:0] rd_addr = i_haddr[7:0];
  // Unmapped offsets read as zero
  wire [31:0] rd_mux =
    (rd_addr == `MPRC_OFS_CTRL) ? {31'h00000000, pincfg_r} :
    (rd_addr == `MPRC_OFS_STATUS) ? status_w :
    (rd_addr == `MPRC_OFS_FUNC) ? {29'h00000000, fun_r} : 32'h00000000;

  // Read data register, loaded at the end of the address phase
  // It then stands for the whole data phase, as the bus expects
  // Limitation: a read right behind a write sees the old value
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_hrdata <= 32'h00000000;
    end else if (ahb_go & ~i_hwrite) begin
      o_hrdata <= rd_mux;
    end
  end

  // Outputs; baseband reset leaves the power domain untouched
  // The bus is never stretched and never answers with an error
  assign o_hreadyout = 1'b1;
  assign o_hresp = 1'b0;
  assign o_powered = (state_r != MPRC_OFF);
  assign o_bb_rst = bb_rst_r | (state_r == MPRC_OFF);
  assign o_rf_en = rf_ok;
  // SIM stays up through a baseband restart; RF does not
  assign o_sim_en = running & (fun_r != `MPRC_FUN_MIN);
  assign o_rf_cmd_ack = ack_r;
  assign o_rf_cmd_rej = rej_r;

endmodule : mprc_power_ctrl

// >>> bench/mprc_power_ctrl_monitor.sv
// Port assertions for the power sequencer
`timescale 1ns/1ps
module mprc_power_ctrl_monitor #(
  parameter int unsigned ON_CYCLES = 50,
  parameter int unsigned OFF_CYCLES = 65,
  parameter int unsigned RST_CYCLES = 30
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_power_key_n,
  input wire logic i_restart_n,
  input wire logic i_rf_cmd_req,
  input wire logic o_hreadyout,
  input wire logic o_hresp,
  input wire logic o_powered,
  input wire logic o_bb_rst,
  input wire logic o_rf_en,
  input wire logic o_sim_en,
  input wire logic o_rf_cmd_ack,
  input wire logic o_rf_cmd_rej
);
  logic [15:0] key_lo_r; // Raw key low run
  logic [15:0] rst_lo_r; // Raw restart low run
  logic [15:0] rst_last_r; // Length of last restart press
  // Run counters on the raw pins; the design lags them by its sync flops
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      key_lo_r <= 16'h0;
      rst_lo_r <= 16'h0;
      rst_last_r <= 16'h0;
    end else begin
      key_lo_r <= i_power_key_n ? 16'h0 : key_lo_r + 16'h1;
      rst_lo_r <= i_restart_n ? 16'h0 : rst_lo_r + 16'h1;
      rst_last_r <= (i_restart_n && rst_lo_r != 16'h0) ? rst_lo_r : rst_last_r;
    end
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // Baseband reset starting while powered
  sequence s_bb_restart;
    $rose(o_bb_rst) && o_powered;
  endsequence
  property p_bus; o_hreadyout && !o_hresp; endproperty
  property p_off_out; !o_powered |-> o_bb_rst && !o_rf_en && !o_sim_en; endproperty
  property p_on_min; $rose(o_powered) |-> key_lo_r >= ON_CYCLES; endproperty
  property p_idle; (!o_powered && i_power_key_n) [*4] |=> !o_powered; endproperty
  property p_hold_on; o_powered && key_lo_r > OFF_CYCLES |=> o_powered; endproperty
  property p_rst_min; s_bb_restart |-> rst_last_r >= RST_CYCLES; endproperty
  property p_rst_keep; s_bb_restart |=> o_powered [*8]; endproperty
  property p_rf_sim; o_rf_en |-> o_sim_en && o_powered; endproperty
  property p_rej; i_rf_cmd_req && !o_rf_en |=> o_rf_cmd_rej && !o_rf_cmd_ack; endproperty
  property p_ack; i_rf_cmd_req && o_rf_en |=> o_rf_cmd_ack && !o_rf_cmd_rej; endproperty
  a_bus: assert property (p_bus) else $error("bus not ready or error");
  a_off_out: assert property (p_off_out) else $error("live output when off");
  a_on_min: assert property (p_on_min) else $error("turn-on press too short");
  a_idle: assert property (p_idle) else $error("start with key idle");
  a_hold_on: assert property (p_hold_on) else $error("off while key held");
  a_rst_min: assert property (p_rst_min) else $error("restart press too short");
  a_rst_keep: assert property (p_rst_keep) else $error("restart lost power");
  a_rf_sim: assert property (p_rf_sim) else $error("rf without sim");
  a_rej: assert property (p_rej) else $error("rf command not refused");
  a_ack: assert property (p_ack) else $error("rf command not accepted");
endmodule : mprc_power_ctrl_monitor
bind mprc_power_ctrl mprc_power_ctrl_monitor #(
  .ON_CYCLES(ON_CYCLES),
  .OFF_CYCLES(OFF_CYCLES),
  .RST_CYCLES(RST_CYCLES)
) u_mprc_power_ctrl_monitor (
  .i_clk(i_clk), .i_rst(i_rst), .i_power_key_n(i_power_key_n), .i_restart_n(i_restart_n),
  .i_rf_cmd_req(i_rf_cmd_req), .o_hreadyout(o_hreadyout), .o_hresp(o_hresp),
  .o_powered(o_powered), .o_bb_rst(o_bb_rst), .o_rf_en(o_rf_en), .o_sim_en(o_sim_en),
  .o_rf_cmd_ack(o_rf_cmd_ack), .o_rf_cmd_rej(o_rf_cmd_rej)
);

// >>> bench/mprc_host_model.sv
// Host controller model driving the control pins
`timescale 1ns/1ps
module mprc_host_model #(
  parameter int unsigned SUPPLY_WAIT = 20
) (
  input wire logic i_clk,
  output logic o_power_key_n,
  output logic o_restart_n,
  output logic o_rf_off_n
);
  // Pins idle high, as their pull-ups leave them
  initial begin
    o_power_key_n = 1'b1;
    o_restart_n = 1'b1;
    o_rf_off_n = 1'b1;
  end
  // Set one pin: 0 key, 1 restart, else RF-off
  task automatic drive(input int pin, input logic v);
    case (pin)
      0: o_power_key_n <= v;
      1: o_restart_n <= v;
      default: o_rf_off_n <= v;
    endcase
  endtask : drive
  // Hold a pin low for a count of cycles, then release
  task automatic press(input int pin, input int cyc);
    @(posedge i_clk);
    drive(pin, 1'b0);
    repeat (cyc) @(posedge i_clk);
    drive(pin, 1'b1);
  endtask : press
  // Settle after supply; power never cut while running
  task automatic supply_wait();
    repeat (SUPPLY_WAIT) @(posedge i_clk);
  endtask : supply_wait
endmodule : mprc_host_model

// >>> bench/mprc_power_ctrl_bench.sv
// Self-checking bench for the power sequencer
`timescale 1ns/1ps
`include "mprc_map.svh"
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin num_errors++; \
  $display("Error at %0t: got %0h exp %0h", $time, (g), (e)); end end
module mprc_power_ctrl_bench;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic key_n, rst_n, rfoff_n; // Host pins
  logic rf_req = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h0;
  logic [31:0] hwdata = 32'h0;
  logic hsel = 1'b0;
  logic hready, hresp, pwr, bbr, rfen, simen, ack, rej;
  logic [31:0] hrdata; // Read data, checked by the rd callers
  wire logic [2:0] mon = {rfen, bbr, pwr};
  int num_errors = 0;
  int total_checks = 0;
  // 50 MHz clock
  always #10 i_clk = ~i_clk;
  mprc_host_model u_mprc_host_model (.i_clk(i_clk), .o_power_key_n(key_n),
    .o_restart_n(rst_n), .o_rf_off_n(rfoff_n));
  // Short counts keep the run brief
  mprc_power_ctrl #(.ON_CYCLES(50), .OFF_CYCLES(65), .RST_CYCLES(30), .BOOT_CYCLES(10),
    .LOGOUT_CYCLES(100)) u_mprc_power_ctrl (.i_clk(i_clk), .i_rst(i_rst),
    .i_power_key_n(key_n), .i_restart_n(rst_n), .i_rf_off_n(rfoff_n), .i_rf_cmd_req(rf_req),
    .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata),
    .i_hsel(hsel), .i_hready(hready), .o_hrdata(hrdata), .o_hreadyout(hready),
    .o_hresp(hresp), .o_powered(pwr), .o_bb_rst(bbr), .o_rf_en(rfen), .o_sim_en(simen),
    .o_rf_cmd_ack(ack), .o_rf_cmd_rej(rej));
  // Verdict and end of run
  task automatic results();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : results
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
  endtask : tick
  // Bounded wait for mon[idx] to reach v
  task automatic wt(input int idx, input logic v, input int lim);
    int n;
    n = 0;
    while (mon[idx] !== v) begin
      n++;
      if (n > lim) begin
        num_errors++;
        $display("Error at %0t: got %0h exp %0h", $time, mon[idx], v);
        results();
      end
      @(posedge i_clk);
    end
  endtask : wt
  // One bus phase, held until ready is sampled high
  task automatic rdy();
    int n;
    n = 0;
    @(posedge i_clk);
    while (hready !== 1'b1) begin
      n++;
      if (n > 50) begin
        num_errors++;
        $display("Error at %0t: got %0h exp %0h", $time, hready, 1'b1);
        results();
      end
      @(posedge i_clk);
    end
  endtask : rdy
  // Single word write
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge i_clk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= 1'b1;
    hsize <= 3'h2;
    htrans <= 2'h2;
    rdy();
    htrans <= 2'h0;
    hwdata <= d;
    rdy();
    hsel <= 1'b0;
  endtask : wr
  // Single word read; data taken at the data-phase edge
  task automatic rd(input logic [31:0] a, output logic [31:0] d);
    @(posedge i_clk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= 1'b0;
    hsize <= 3'h2;
    htrans <= 2'h2;
    rdy();
    htrans <= 2'h0;
    rdy();
    d = hrdata;
    hsel <= 1'b0;
  endtask : rd
  // RF-dependent request; answer may land one or two edges on
  task automatic pulse(input logic ea);
    logic a, r;
    @(posedge i_clk);
    rf_req <= 1'b1;
    @(posedge i_clk);
    rf_req <= 1'b0;
    #1 a = ack;
    r = rej;
    @(posedge i_clk);
    #1 a = a | ack;
    r = r | rej;
    `CHK(a, ea)
    `CHK(r, !ea)
  endtask : pulse
  task automatic t_reset();
    `CHK(pwr, 1'b0)
    `CHK(bbr, 1'b1)
    `CHK({rfen, simen}, 2'h0)
  endtask : t_reset
  // A short key press and a long restart press while off change nothing
  task automatic t_off_ignore();
    u_mprc_host_model.press(0, 40);
    tick(10);
    `CHK(pwr, 1'b0)
    u_mprc_host_model.press(1, 40);
    tick(5);
    `CHK({pwr, bbr}, 2'h1)
  endtask : t_off_ignore
  task automatic t_power_on();
    u_mprc_host_model.press(0, 60);
    tick(5);
    wt(1, 1'b0, 60);
    `CHK(pwr, 1'b1)
    `CHK({rfen, simen}, 2'h3)
  endtask : t_power_on
  // Reset follows release, power domain holds
  task automatic t_restart();
    u_mprc_host_model.press(1, 35);
    `CHK(bbr, 1'b0)
    wt(1, 1'b1, 10);
    `CHK(pwr, 1'b1)
    wt(1, 1'b0, 20);
  endtask : t_restart
  task automatic t_airplane();
    logic [31:0] d;
    u_mprc_host_model.drive(2, 1'b0);
    tick(5);
    `CHK(rfen, 1'b1)
    wr(32'h0, 32'h1);
    rd(32'h0, d);
    `CHK(d[`MPRC_CTRL_PINCFG], 1'b1)
    tick(4);
    `CHK(rfen, 1'b0)
    pulse(1'b0);
    wr(32'hC, 32'h2);
    #1;
    `CHK(rej, 1'b1)
    rd(32'h4, d);
    `CHK(d[`MPRC_ST_RF_REJ], 1'b1)
    `CHK(d[`MPRC_ST_AIRPLANE], 1'b1)
    rd(32'h4, d);
    `CHK(d[`MPRC_ST_RF_REJ], 1'b0)
    u_mprc_host_model.drive(2, 1'b1);
    tick(5);
    pulse(1'b1);
  endtask : t_airplane
  // Every code, one illegal code, one unmapped address
  task automatic t_func();
    logic [31:0] ad [5] = '{32'h8, 32'h8, 32'h8, 32'h8, 32'h40};
    logic [31:0] cd [5] = '{32'h0, 32'h4, 32'h1, 32'h2, 32'h0};
    logic [1:0] ex [5] = '{2'h0, 2'h1, 2'h3, 2'h3, 2'h3};
    logic [2:0] ef [5] = '{3'h0, 3'h4, 3'h1, 3'h1, 3'h1};
    logic [31:0] d;
    for (int i = 0; i < 5; i++) begin
      wr(ad[i], cd[i]);
      tick(4);
      `CHK({rfen, simen}, ex[i])
      rd(32'h8, d);
      `CHK(d[2:0], ef[i])
    end
  endtask : t_func
  task automatic t_key_off();
    u_mprc_host_model.press(0, 70);
    `CHK(pwr, 1'b1)
    wt(0, 1'b0, 130);
    `CHK(bbr, 1'b1)
  endtask : t_key_off
  // Shutdown command, key kept idle
  task automatic t_cmd_off();
    wr(32'hC, 32'h1);
    wt(0, 1'b0, 130);
    tick(80);
    `CHK(pwr, 1'b0)
  endtask : t_cmd_off
  initial begin
    tick(6);
    i_rst <= 1'b0;
    u_mprc_host_model.supply_wait();
    t_reset();
    t_off_ignore();
    t_power_on();
    t_restart();
    t_airplane();
    t_func();
    t_key_off();
    t_power_on();
    t_cmd_off();
    results();
  end
endmodule : mprc_power_ctrl_bench
